// ---- src/asbp_host.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "asbp_params.svh"
module asbp_host
#(
   // Startup length in clocks; a bench may shorten it to keep runs short.
   parameter int unsigned BOOT_CYCLES = `ASBP_STARTUP_CYC
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic req_valid,
   input wire asbp_pkg::asbp_req_t req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic [18:0] mem_addr,
   output asbp_pkg::asbp_ctl_t mem_ctl,
   output logic [7:0] mem_dq_out,
   output logic mem_dq_oe,
   input wire logic [7:0] mem_dq_in
);
   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   // Read waits for the slower of address access and enable access.
   localparam logic [`ASBP_CNT_W-1:0] RD_CYC = `ASBP_CNT_W'(`ASBP_CEIL(`ASBP_READ_ACC_NS));
   // Strobe width covers pulse, data setup and address-to-end figures.
   localparam logic [`ASBP_CNT_W-1:0] WR_CYC = `ASBP_CNT_W'(`ASBP_CEIL(`ASBP_ADDR_END_NS));
   // Recovery covers address hold after write, output release and the high time.
   localparam logic [`ASBP_CNT_W-1:0] REC_CYC = `ASBP_CNT_W'(`ASBP_CEIL(`ASBP_RECOVERY_NS));
   localparam logic [`ASBP_CNT_W-1:0] BOOT_CYC = `ASBP_CNT_W'(BOOT_CYCLES);
   localparam logic [`ASBP_CNT_W-1:0] ONE = `ASBP_CNT_W'(1);

   asbp_pkg::asbp_state_t state_q, state_d;
   logic [`ASBP_CNT_W-1:0] cnt_q, cnt_d;
   logic [18:0] addr_q, addr_d;
   logic [7:0] wdata_q, wdata_d, rdata_q, rdata_d;
   asbp_pkg::asbp_ctl_t ctl_q, ctl_d;
   logic oe_q, oe_d, ready_q, ready_d, rvalid_q, rvalid_d;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      ctl_d = ctl_q;
      oe_d = oe_q;
      ready_d = 1'b0;
      rvalid_d = 1'b0;
      case (state_q)
         asbp_pkg::ASBP_BOOT:
         begin
            // Controls stay high while the memory starts up.
            ctl_d = '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1}; // R19
            cnt_d = cnt_q + ONE;
            if (cnt_q >= BOOT_CYC) // R18
            begin
               state_d = asbp_pkg::ASBP_IDLE;
               cnt_d = `ASBP_CYC_ZERO;
               ready_d = 1'b1;
            end
         end
         asbp_pkg::ASBP_IDLE:
         begin
            ready_d = 1'b1;
            if (req_valid && ready_q)
            begin
               ready_d = 1'b0;
               // Address is placed together with chip select, zero setup.
               addr_d = req.addr; // R11 R20
               wdata_d = req.wdata;
               cnt_d = ONE;
               if (req.write)
               begin
                  // Output drive stays high so the device keeps its bus released.
                  ctl_d = '{cs_n: 1'b0, we_n: 1'b0, oe_n: 1'b1}; // R7 R8
                  oe_d = 1'b1; // R13
                  state_d = asbp_pkg::ASBP_WR;
               end
               else
               begin
                  // The host leaves its driver off, so the device may turn on at will.
                  ctl_d = '{cs_n: 1'b0, we_n: 1'b1, oe_n: 1'b0}; // R1 R2 R3 R5
                  state_d = asbp_pkg::ASBP_RD;
               end
            end
         end
         asbp_pkg::ASBP_RD:
         begin
            cnt_d = cnt_q + ONE;
            if (cnt_q >= RD_CYC) // R2 R3 R10
            begin
               // Sampled before the address moves, so no output hold margin is spent.
               rdata_d = mem_dq_in; // R4
               rvalid_d = 1'b1;
               ctl_d = '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1}; // R6
               cnt_d = ONE;
               state_d = asbp_pkg::ASBP_REC;
            end
         end
         asbp_pkg::ASBP_WR:
         begin
            cnt_d = cnt_q + ONE;
            if (cnt_q >= WR_CYC) // R12 R16 R11 R13
            begin
               // Both rise together, so the device never turns its driver on.
               ctl_d = '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1}; // R17 R14
               cnt_d = ONE;
               state_d = asbp_pkg::ASBP_REC;
            end
         end
         default:
         begin
            // Data is held one cycle past the write end, address until recovery ends.
            oe_d = 1'b0;
            cnt_d = cnt_q + ONE;
            if (cnt_q >= REC_CYC) // R15 R9 R10
            begin
               state_d = asbp_pkg::ASBP_IDLE;
               cnt_d = `ASBP_CYC_ZERO;
               ready_d = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_q <= asbp_pkg::ASBP_BOOT;
         cnt_q <= `ASBP_CYC_ZERO;
         addr_q <= `ASBP_ADDR_ZERO;
         wdata_q <= `ASBP_BYTE_ZERO;
         rdata_q <= `ASBP_BYTE_ZERO;
         ctl_q <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
         oe_q <= 1'b0;
         ready_q <= 1'b0;
         rvalid_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         ctl_q <= ctl_d;
         oe_q <= oe_d;
         ready_q <= ready_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign req_ready = ready_q;
   assign rsp_valid = rvalid_q;
   assign rsp_data = rdata_q;
   assign mem_addr = addr_q;
   assign mem_ctl = ctl_q;
   assign mem_dq_out = wdata_q;
   assign mem_dq_oe = oe_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   read_we_high_a: assert property ((!ctl_q.cs_n && !ctl_q.oe_n) |-> ctl_q.we_n) // R1
      else $error("write strobe low during read");
   no_drive_read_a: assert property (!ctl_q.oe_n |-> !oe_q) // R8
      else $error("host drives data while output drive low");
   write_pair_a: assert property (ctl_q.we_n == 1'b0 |-> ctl_q.cs_n == 1'b0) // R7
      else $error("write strobe without chip select");
   write_width_a: assert property ($fell(ctl_q.we_n) |-> !ctl_q.we_n [*3]) // R12
      else $error("write strobe too short");
   write_end_a: assert property ($rose(ctl_q.we_n) |-> $rose(ctl_q.cs_n)) // R17
      else $error("chip select and strobe do not rise together");
   data_hold_a: assert property ($rose(ctl_q.we_n) |-> oe_q && $stable(mem_dq_out)) // R13
      else $error("write data not held at write end");
   addr_stable_a: assert property ($rose(ctl_q.cs_n) |-> $stable(addr_q) [*2]) // R15
      else $error("address changed during recovery");
   cs_high_a: assert property ($rose(ctl_q.cs_n) |-> ctl_q.cs_n [*2]) // R9
      else $error("chip select reasserted too soon");
   // Five clocks of 8 ns are the shortest fall-to-fall spacing that covers the cycle time.
   cycle_sp_a: assert property ($fell(ctl_q.cs_n) |=> !$fell(ctl_q.cs_n) [*4]) // R10
      else $error("cycle too short");
   boot_hold_a: assert property ((state_q == asbp_pkg::ASBP_BOOT) |-> ctl_q.cs_n && ctl_q.we_n) // R19
      else $error("controls active during startup");
   read_len_a: assert property ($fell(ctl_q.oe_n) |-> !ctl_q.oe_n [*5]) // R2
      else $error("read ended before access time");
   read_resp_a: assert property ($rose(ctl_q.oe_n) |-> rvalid_q) // R2
      else $error("read closed without a response");
   write_data_a: assert property ($fell(ctl_q.we_n) |-> oe_q) // R13
      else $error("write data not driven at write start");
   // Data lines are let go one cycle after the write closes, never before it.
   data_release_a: assert property ($rose(ctl_q.cs_n) |=> !oe_q) // R13
      else $error("data driver left on after recovery start");
   write_oe_a: assert property (!ctl_q.we_n |-> ctl_q.oe_n) // R8
      else $error("output drive low during write");
   addr_sel_a: assert property ((!ctl_q.cs_n && !$fell(ctl_q.cs_n)) |-> $stable(addr_q)) // R11
      else $error("address moved while selected");
   // A shortened startup count must still be honoured in full.
   boot_early_a: assert property ((state_q == asbp_pkg::ASBP_BOOT && cnt_q < BOOT_CYC) // R18
      |=> state_q == asbp_pkg::ASBP_BOOT)
      else $error("startup ended before its count");

   // ----------------------------------------------------------------
   // Coverage
   // ----------------------------------------------------------------
   rd_c: cover property ($rose(rsp_valid));
   wr_c: cover property ($rose(ctl_q.we_n));
   b2b_c: cover property ($rose(ctl_q.cs_n) ##[1:4] $fell(ctl_q.cs_n));
   boot_c: cover property ($fell(state_q == asbp_pkg::ASBP_BOOT));
endmodule
`default_nettype wire

// ---- src/asbp_params.svh ----
// Function
// R1: Host keeps write strobe high during every read cycle.
// R2: Read data valid 35 ns after address or chip select fall.
// R3: Read data valid 15 ns after output drive falls.
// R4: Device holds old read data 3 ns after address change.
// R5: Device drives data no sooner than 3 ns after chip select falls.
// R6: Device releases data 15 ns after chip select, 10 ns after output drive rise.
// R7: Write happens only while chip select and write strobe both low.
// R8: Output drive falling with or after strobe keeps data lines released.
// R9: Chip select and write strobe stay high 2 ns before reassertion.
// R10: Chip select falls and address changes spaced by 35 ns cycle.
// R11: Address valid at write start, 18 or 20 ns before write end.
// R12: Write strobe held low at least 15 ns.
// R13: Write data valid 10 ns before write end, held 0 ns after.
// R14: Device releases data 12 ns after strobe falls, drives 3 ns after rise.
// R15: Address stable 12 ns after write ends.
// R16: Chip select low at least 15 ns before write end.
// R17: Chip select rising with or before strobe keeps data released.
// R18: No access for 2 ms after supply reaches minimum.
// R19: Host holds chip select and strobe high past startup interval.
// R20: Memory is 524288 bytes, 19-bit address, one byte per access.
`ifndef ASBP_PARAMS_SVH
`define ASBP_PARAMS_SVH
`define ASBP_CLK_PS 8000
`define ASBP_CYCLE_NS 35
`define ASBP_READ_ACC_NS 35
`define ASBP_OE_ACC_NS 15
`define ASBP_OE_HIZ_NS 10
`define ASBP_ADDR_END_NS 20
`define ASBP_WE_PULSE_NS 15
`define ASBP_DATA_SETUP_NS 10
`define ASBP_RECOVERY_NS 12
`define ASBP_HIGH_NS 2
`define ASBP_STARTUP_MS 2
`define ASBP_CEIL(ns) ((((ns) * 1000) + `ASBP_CLK_PS - 1) / `ASBP_CLK_PS)
`define ASBP_STARTUP_CYC (`ASBP_STARTUP_MS * 1000 * 1000 * 1000 / `ASBP_CLK_PS)
`define ASBP_CNT_W 18
`define ASBP_CYC_ZERO 18'h00000
`define ASBP_ADDR_ZERO 19'h00000
`define ASBP_BYTE_ZERO 8'h00
`endif

// ---- src/asbp_pkg.sv ----
package asbp_pkg;
   typedef struct packed
   {
      logic write;
      logic [18:0] addr;
      logic [7:0] wdata;
   } asbp_req_t;

   typedef struct packed
   {
      logic cs_n;
      logic we_n;
      logic oe_n;
   } asbp_ctl_t;

   typedef enum logic [2:0]
   {
      ASBP_BOOT = 3'b000,
      ASBP_IDLE = 3'b001,
      ASBP_RD = 3'b010,
      ASBP_WR = 3'b011,
      ASBP_REC = 3'b100
   } asbp_state_t;
endpackage

// ---- tb/asbp_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module asbp_mem_model
#(
   parameter real BOOT_T = 2.0e6
)
(
   input wire logic [18:0] mem_addr,
   input wire asbp_pkg::asbp_ctl_t mem_ctl,
   input wire logic [7:0] mem_dq_out,
   input wire logic mem_dq_oe,
   input wire logic slow,
   output logic [7:0] mem_dq_in
);
   logic [7:0] cells [int];
   logic [7:0] rd_q = 8'h00;
   logic drv_q = 1'b0;
   logic wr_q = 1'b0;
   wire rd_on = !mem_ctl.cs_n && !mem_ctl.oe_n && mem_ctl.we_n;
   // Released lines show the inverse byte, so a stale value never passes for data.
   assign mem_dq_in = mem_dq_oe ? mem_dq_out : (drv_q ? rd_q : ~rd_q);
   always @(rd_on or mem_addr)
   begin
      drv_q <= #3 rd_on;
      rd_q <= #(slow ? 35 : 4) (cells.exists(mem_addr) ? cells[mem_addr] : ~mem_addr[7:0]);
   end
   always @(mem_ctl)
   begin
      if (!mem_ctl.cs_n && !mem_ctl.we_n && $realtime >= BOOT_T)
         wr_q = 1'b1;
      else if (wr_q)
      begin
         // Storing what stands on the lines catches a host that lets go of data too early.
         cells[mem_addr] = mem_dq_in;
         wr_q = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- tb/async_sram_bus_port_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module async_sram_bus_port_test;
   // Reset spans twelve cycles and the host may go ready on the edge after the count.
   localparam int BOOT_N = 200;
   localparam real BOOT_T = 8.0 * (BOOT_N + 12) + 4.0;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic req_valid = 1'b0;
   logic slow = 1'b0;
   asbp_pkg::asbp_req_t req = 28'h0000000;
   logic req_ready, rsp_valid, mem_dq_oe, cs_was, we_was;
   logic [7:0] rsp_data, mem_dq_out, mem_dq_in;
   logic [18:0] mem_addr, held_addr, a;
   asbp_pkg::asbp_ctl_t mem_ctl;
   logic [7:0] shadow [int];
   int failures = 0;
   int check_count = 0;
   int low_n = 0;
   int gap_n = 9;
   int rec_n = 9;
   always #4 clk = ~clk;
   asbp_host #(.BOOT_CYCLES(BOOT_N)) u_dut (.clk(clk), .resetn(resetn),
      .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .mem_addr(mem_addr), .mem_ctl(mem_ctl), .mem_dq_out(mem_dq_out),
      .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in));
   asbp_mem_model #(.BOOT_T(BOOT_T)) u_mem (.mem_addr(mem_addr), .mem_ctl(mem_ctl),
      .mem_dq_out(mem_dq_out),
      .mem_dq_oe(mem_dq_oe), .slow(slow), .mem_dq_in(mem_dq_in));
   task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [7:0] exp_rd(input logic [18:0] ad);
      return shadow.exists(ad) ? shadow[ad] : ~ad[7:0];
   endfunction
   task automatic wait_flag(input bit on_rsp, input int lim);
      int n;
      n = 0;
      while ((on_rsp ? rsp_valid : req_ready) !== 1'b1)
      begin
         @(posedge clk);
         #1;
         n++;
         if (n > lim)
         begin
            chk("handshake_wait", 19'h00001, 19'h00000);
            give_verdict();
         end
      end
   endtask
   task automatic do_req(input logic wr, input logic [18:0] ad, input logic [7:0] d);
      req = {wr, ad, d};
      req_valid = 1'b1;
      wait_flag(1'b0, 1000);
      @(posedge clk);
      #1;
      if (wr)
         shadow[ad] = d;
      else
      begin
         req_valid = 1'b0;
         wait_flag(1'b1, 12);
         chk("read_byte", {11'h000, exp_rd(ad)}, {11'h000, rsp_data});
      end
   endtask
   // -----------------------------------------------
   // Pin monitor, sampled mid-cycle where all is settled.
   // -----------------------------------------------
   always @(negedge clk)
   begin
      if ($realtime < BOOT_T)
         chk("boot_ctl", 19'h00006, {16'h0000, mem_ctl.cs_n, mem_ctl.we_n, req_ready});
      if (!mem_ctl.oe_n)
         chk("strobe_in_read", 19'h00001, {18'h00000, mem_ctl.we_n});
      if (!mem_ctl.cs_n && cs_was)
      begin
         held_addr = mem_addr;
         chk("select_spacing", 19'h00001, {18'h00000, gap_n >= 5});
      end
      if (mem_ctl.cs_n && !cs_was)
      begin
         chk("select_width", 19'h00001, {18'h00000, low_n >= 2});
         if (!we_was)
            chk("write_drive", 19'h00001, {18'h00000, mem_dq_oe});
      end
      if (!mem_ctl.cs_n || rec_n < 2)
         chk("addr_hold", held_addr, mem_addr);
      gap_n = (!mem_ctl.cs_n && cs_was) ? 1 : gap_n + 1;
      low_n = mem_ctl.cs_n ? 0 : low_n + 1;
      rec_n = mem_ctl.cs_n ? rec_n + 1 : 0;
      cs_was = mem_ctl.cs_n;
      we_was = mem_ctl.we_n;
   end
   initial
   begin
      cs_was = 1'b1;
      we_was = 1'b1;
      held_addr = 19'h00000;
      void'($urandom(84));
      repeat (12) @(posedge clk);
      #1;
      resetn = 1'b1;
      do_req(1'b1, 19'h00000, 8'h00);
      do_req(1'b1, 19'h7ffff, 8'hff);
      do_req(1'b0, 19'h7ffff, 8'h00);
      do_req(1'b0, 19'h00000, 8'h00);
      do_req(1'b0, 19'h12345, 8'h00);
      for (int i = 0; i < 60; i++)
      begin
         a = 19'($urandom) & 19'h7000f;
         slow = 1'($urandom);
         do_req(1'($urandom), a, 8'($urandom));
      end
      do_req(1'b0, a, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
